// ===== logic/xmc_pkg.sv
// Package: constants and types for the external memory interface controller
package xmc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int REG_AW = 1;
    localparam logic [REG_AW-1:0] OFS_CTRL_A = 1'h0;
    localparam logic [REG_AW-1:0] OFS_CTRL_B = 1'h1;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    // Writable bits of control B; bits 6..3 are reserved
    localparam logic [7:0] CTRL_B_WMASK = 8'h87;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CA_ENABLE_BIT = 7;
    localparam int CA_LIMIT_LSB = 4;
    localparam int CA_UPPER_LSB = 2;
    localparam int CA_LOWER_LSB = 0;
    localparam int CB_KEEPER_BIT = 7;
    localparam int CB_MASK_LSB = 0;

    // ------------------------------------------------------------
    // Decode and timing constants
    // ------------------------------------------------------------
    localparam int SECTOR_LSB = 13;
    localparam logic [2:0] LIMIT_NONE = 3'h0;
    localparam logic [2:0] MASK_ALL_RELEASED = 3'h7;
    localparam logic [1:0] WS_NONE = 2'h0;
    localparam logic [1:0] WS_ONE = 2'h1;
    localparam logic [1:0] WS_TWO = 2'h2;
    localparam logic [1:0] WS_TWO_GAP = 2'h3;
    localparam int SYNC_STAGES = 2;
    // Base strobe spans the two pin flops, so code 00 read data still lands in time
    localparam logic [2:0] STROBE_BASE = 3'h3;
    localparam logic [15:0] INT_SRAM_END_DEF = 16'h10FF;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ALE = 3'b001,
        ST_STROBE = 3'b010,
        ST_GAP = 3'b011,
        ST_DONE = 3'b100
    } xmc_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic write;
    } xmc_req_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] ddr;
    } xmc_port_t;

    typedef struct packed {
        logic [2:0] out;
        logic [2:0] ddr;
    } xmc_ctl_port_t;

endpackage

// ===== logic/xmc_keeper.sv
// Pin input synchroniser and bus-keeper level holder for the muxed lines
`timescale 1ns/1ps
module xmc_keeper
    import xmc_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] pin_i,
    input wire logic [W-1:0] drive_n_i,
    input wire logic [W-1:0] drive_val_i,
    input wire logic keep_en_i,
    output logic [W-1:0] sync_o,
    output logic [W-1:0] keep_o,
    output logic [W-1:0] keep_val_o
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] last_reg;
    logic [W-1:0] last_next;

    // ------------------------------------------------------------
    // Two-stage synchroniser; only sync_reg reads meta_reg
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Keeper: remember driven value, else the observed level
    // ------------------------------------------------------------
    assign last_next = (~drive_n_i & drive_val_i) | (drive_n_i & sync_reg);

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            last_reg <= '0;
        end else begin
            last_reg <= last_next;
        end
    end

    assign sync_o = sync_reg;
    assign keep_o = {W{keep_en_i}} & drive_n_i;
    assign keep_val_o = last_reg;

endmodule

// ===== logic/xmc_ctrl.sv
// External memory interface controller: control registers, sector decode, wait states, pin override
//
// What this block does
// - Enable bit hands muxed, high address and strobe pins to the interface.
// - While enabled the interface drives its pins whatever the direction bits say.
// - With interface off, addresses above internal SRAM never fold onto it.
// - Sector limit zero makes one sector using the upper wait-state field.
// - Nonzero limit k starts upper sector at k times 0x2000 up to 0xFFFF.
// - Bits 3..2 give wait states for the upper sector.
// - Bits 1..0 give wait states for the lower sector.
// - Codes add 0, 1, 2 strobe cycles; code 3 adds a gap before next address.
// - Keeper enabled holds last level on undriven muxed lines.
// - Keeper works whether or not the interface is enabled.
// - Reserved control B bits 6..3 read zero; software writes zero.
// - Mask zero puts all eight high address bits on the high port.
// - Mask code sets driven high bits: 8, 7 down to 2, or none.
// - Released high pins show port values so software can reach low memory.
// - By default only addresses above internal memory go external.
// - Low address is valid on muxed lines when the latch strobe falls.
// - Internal accesses toggle address and latch lines but never the strobes.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module xmc_ctrl
    import xmc_pkg::*;
#(
    parameter logic [15:0] INT_SRAM_END = INT_SRAM_END_DEF
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [REG_AW-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic req_valid_i,
    input wire xmc_req_t req_i,
    output logic req_ready_o,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic ext_o,
    input wire xmc_port_t port_ad_i,
    input wire xmc_port_t port_hi_i,
    input wire xmc_ctl_port_t port_ctl_i,
    input wire logic [7:0] ad_pin_i,
    output logic [7:0] ad_out_o,
    output logic [7:0] ad_oe_n_o,
    output logic [7:0] ad_keep_o,
    output logic [7:0] ad_keep_val_o,
    output logic [7:0] hi_out_o,
    output logic [7:0] hi_oe_n_o,
    output logic [2:0] ctl_out_o,
    output logic [2:0] ctl_oe_n_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Extra strobe cycles per wait code
    function automatic logic [2:0] ws_extra(input logic [1:0] code);
        ws_extra = (code == WS_NONE) ? 3'h0 : (code == WS_ONE) ? 3'h1 : 3'h2;
    endfunction

    // High bits driven per mask code, from bit 0 upward
    function automatic logic [7:0] hi_drive_mask(input logic [2:0] code);
        hi_drive_mask = (code == MASK_ALL_RELEASED) ? 8'h00 : (8'hFF >> code);
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_a_reg;
    logic [7:0] ctrl_b_reg;
    logic [7:0] reg_rdata_reg;
    xmc_state_t state_reg;
    xmc_state_t state_next;
    logic [15:0] addr_reg;
    logic [7:0] wdata_reg;
    logic write_reg;
    logic int_reg;
    logic [1:0] ws_reg;
    logic [2:0] cnt_reg;
    logic [7:0] rdata_reg;
    logic ext_reg;

    wire ext_mem_enable = ctrl_a_reg[CA_ENABLE_BIT];
    wire [2:0] sector_limit = ctrl_a_reg[CA_LIMIT_LSB +: 3];
    wire [1:0] upper_wait = ctrl_a_reg[CA_UPPER_LSB +: 2];
    wire [1:0] lower_wait = ctrl_a_reg[CA_LOWER_LSB +: 2];
    wire bus_keeper_enable = ctrl_b_reg[CB_KEEPER_BIT];
    wire [2:0] high_addr_mask = ctrl_b_reg[CB_MASK_LSB +: 3];

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    wire sel_a = reg_addr_i == OFS_CTRL_A;
    wire sel_b = reg_addr_i == OFS_CTRL_B;
    wire [7:0] ctrl_b_view = ctrl_b_reg & CTRL_B_WMASK;
    wire [7:0] reg_rd_mux = sel_a ? ctrl_a_reg : sel_b ? ctrl_b_view : 8'h00;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ctrl_a_reg <= CTRL_A_RESET;
            ctrl_b_reg <= CTRL_B_RESET;
        end else if (reg_wr_i && sel_a) begin
            ctrl_a_reg <= reg_wdata_i;
        end else if (reg_wr_i && sel_b) begin
            ctrl_b_reg <= reg_wdata_i & CTRL_B_WMASK;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_reg <= reg_rd_mux;
        end else begin
            reg_rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata_o = reg_rdata_reg;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // internal range wins, rest goes external
    wire req_internal = req_i.addr <= INT_SRAM_END;
    // limit zero puts all in the upper sector
    wire req_upper = (sector_limit == LIMIT_NONE) || (req_i.addr[15:SECTOR_LSB] >= sector_limit);
    wire [1:0] req_ws = req_upper ? upper_wait : lower_wait;
    wire take = req_valid_i && (state_reg == ST_IDLE);

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    wire strobe_last = cnt_reg == 3'h0;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take && ext_mem_enable) begin
                    state_next = ST_ALE;
                end else if (take) begin
                    state_next = ST_DONE;
                end
            end
            ST_ALE: begin
                state_next = ST_STROBE;
            end
            ST_STROBE: begin
                // code 3 idles one cycle before the next address
                if (strobe_last) begin
                    state_next = (ws_reg == WS_TWO_GAP) ? ST_GAP : ST_DONE;
                end
            end
            ST_GAP: begin
                state_next = ST_DONE;
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    logic [7:0] ad_sync;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
            write_reg <= 1'b0;
            int_reg <= 1'b0;
            ws_reg <= WS_NONE;
            cnt_reg <= 3'h0;
            rdata_reg <= 8'h00;
            ext_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (take) begin
                addr_reg <= req_i.addr;
                wdata_reg <= req_i.wdata;
                write_reg <= req_i.write;
                int_reg <= req_internal;
                ws_reg <= req_ws;
                // disabled external access touches nothing internal
                ext_reg <= !req_internal && ext_mem_enable;
                rdata_reg <= UNMAPPED_DATA;
            end
            if (state_reg == ST_ALE) begin
                // strobe lasts base plus extra cycles
                cnt_reg <= STROBE_BASE + ws_extra(ws_reg) - 3'h1;
            end else if (state_reg == ST_STROBE && !strobe_last) begin
                cnt_reg <= cnt_reg - 3'h1;
            end
            if (state_reg == ST_STROBE && strobe_last && !int_reg && !write_reg) begin
                rdata_reg <= ad_sync;
            end
        end
    end

    assign req_ready_o = state_reg == ST_IDLE;
    assign done_o = state_reg == ST_DONE;
    assign rdata_o = rdata_reg;
    assign ext_o = ext_reg;

    // ------------------------------------------------------------
    // Pin override
    // ------------------------------------------------------------
    wire in_ale = state_reg == ST_ALE;
    wire in_strobe = state_reg == ST_STROBE;
    wire rd_act = in_strobe && !int_reg && !write_reg;
    wire wr_act = in_strobe && !int_reg && write_reg;
    // low address on muxed lines while latch strobe high
    wire ad_drive = in_ale || (in_strobe && write_reg);
    wire [7:0] ad_val = in_ale ? addr_reg[7:0] : wdata_reg;
    wire [7:0] hi_drv = {8{ext_mem_enable}} & hi_drive_mask(high_addr_mask);

    // enable selects memory function, else port
    assign ad_out_o = ext_mem_enable ? (ad_drive ? ad_val : 8'h00) : port_ad_i.out;
    assign ad_oe_n_o = ext_mem_enable ? {8{!ad_drive}} : ~port_ad_i.ddr;
    // mask frees pins from the top down
    assign hi_out_o = (hi_drv & addr_reg[15:8]) | (~hi_drv & port_hi_i.out);
    assign hi_oe_n_o = ~hi_drv & ~port_hi_i.ddr;
    // Control order {store strobe, read strobe, latch}; strobes active low
    assign ctl_out_o = ext_mem_enable ? {!wr_act, !rd_act, in_ale} : port_ctl_i.out;
    assign ctl_oe_n_o = ext_mem_enable ? 3'h0 : ~port_ctl_i.ddr;

    // keeper holds last level on undriven lines
    xmc_keeper #(
        .W(8)
    ) u_keeper (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .pin_i(ad_pin_i),
        .drive_n_i(ad_oe_n_o),
        .drive_val_i(ad_out_o),
        .keep_en_i(bus_keeper_enable),
        .sync_o(ad_sync),
        .keep_o(ad_keep_o),
        .keep_val_o(ad_keep_val_o)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_no_internal_strobe: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (in_strobe && int_reg) |-> (ctl_out_o[2:1] == 2'b11))
        else $error("strobe pulsed on internal access");

    a_pins_taken_over: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ext_mem_enable |-> (ctl_oe_n_o == 3'h0 && (hi_oe_n_o[0] == 1'b0 || high_addr_mask == 3'h7)))
        else $error("enabled interface left a pin undriven");

    a_port_when_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !ext_mem_enable |-> (ad_out_o == port_ad_i.out && ctl_out_o == port_ctl_i.out
            && hi_out_o == port_hi_i.out))
        else $error("disabled interface altered port pins");

    a_high_full: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (ext_mem_enable && high_addr_mask == 3'h0) |-> (hi_oe_n_o == 8'h00 && hi_out_o == addr_reg[15:8]))
        else $error("high address not fully driven");

    a_high_release: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (ext_mem_enable && high_addr_mask == 3'h3) |-> (hi_out_o[7:5] == port_hi_i.out[7:5]
            && hi_oe_n_o[4:0] == 5'h00))
        else $error("wrong high pins released");

    a_latch_addr_valid: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (ext_mem_enable && $fell(ctl_out_o[0])) |-> ($past(ad_out_o) == addr_reg[7:0] && !$past(ad_oe_n_o[0])))
        else $error("no valid low address at latch fall");

    a_keeper_always: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        bus_keeper_enable |-> (ad_keep_o == ad_oe_n_o))
        else $error("keeper inactive while enabled");

    a_reserved_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (reg_rd_i && sel_b) |=> (reg_rdata_o[6:3] == 4'h0))
        else $error("reserved bits read nonzero");

    a_strobe_two_wait: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ($rose(in_strobe) && ws_reg == 2'h2) |-> in_strobe [*5] ##1 (state_reg == ST_DONE))
        else $error("two-wait strobe length wrong");

    a_gap_after_three: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ($fell(in_strobe) && ws_reg == 2'h3) |-> (state_reg == ST_GAP ##1 state_reg == ST_DONE))
        else $error("missing gap after code 3");

    a_sector_pick: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (take && sector_limit == 3'h0) |=> (ws_reg == $past(upper_wait)))
        else $error("single sector used wrong wait code");

endmodule

// ===== bench/xmc_ext_mem.sv
// Behavioural external SRAM behind a transparent address latch
`timescale 1ns/1ps
module xmc_ext_mem (
    input wire logic clock_i,
    input wire logic [7:0] ad_out_i,
    input wire logic [7:0] ad_oe_n_i,
    input wire logic [7:0] ad_keep_i,
    input wire logic [7:0] ad_keep_val_i,
    input wire logic [7:0] hi_pin_i,
    input wire logic [2:0] ctl_out_i,
    output logic [7:0] ad_pin_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] low_q;
    logic [7:0] last_q;
    logic [15:0] addr;
    assign addr = {hi_pin_i, low_q};
    // ------------------------------------------------------------
    // Latch and wire resolution
    // ------------------------------------------------------------
    // low byte held when latch falls
    always_latch begin
        if (ctl_out_i[0]) begin
            low_q = ad_out_i;
        end
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!ad_oe_n_i[i]) begin
                ad_pin_o[i] = ad_out_i[i];
            end else if (!ctl_out_i[1]) begin
                ad_pin_o[i] = mem[addr][i];
            end else if (ad_keep_i[i]) begin
                ad_pin_o[i] = ad_keep_val_i[i];
            end else begin
                // Floating line: never repeat the old level
                ad_pin_o[i] = ~last_q[i];
            end
        end
    end
    // address taken from pins as seen
    always_ff @(posedge clock_i) begin
        last_q <= ad_pin_o;
        if (!ctl_out_i[2]) begin
            mem[addr] <= ad_out_i;
        end
    end
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the external memory interface controller
`timescale 1ns/1ps
module tb_top;
    import xmc_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [REG_AW-1:0] reg_addr_i = '0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic req_valid_i = 1'b0;
    xmc_req_t req_i = '0;
    xmc_port_t port_ad_i = '0;
    xmc_port_t port_hi_i = '{out: 8'h00, ddr: 8'hFF};
    xmc_ctl_port_t port_ctl_i = '{out: 3'h6, ddr: 3'h0};
    logic [7:0] reg_rdata_o, rdata_o, ad_pin_i, ad_out_o, ad_oe_n_o, ad_keep_o, ad_keep_val_o, hi_out_o, hi_oe_n_o;
    logic req_ready_o, done_o, ext_o;
    logic [2:0] ctl_out_o, ctl_oe_n_o;
    int error_cnt = 0;
    int tests_run = 0;
    logic [7:0] ctrl_a = 8'h00;
    logic [7:0] ctrl_b = 8'h00;
    logic [7:0] mem_model [int];
    logic [15:0] a;

    initial begin
        forever #2.5 clock_i = ~clock_i;
    end

    xmc_ctrl xmc_ctrl_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o),
        .rdata_o(rdata_o), .ext_o(ext_o), .port_ad_i(port_ad_i), .port_hi_i(port_hi_i),
        .port_ctl_i(port_ctl_i), .ad_pin_i(ad_pin_i), .ad_out_o(ad_out_o), .ad_oe_n_o(ad_oe_n_o),
        .ad_keep_o(ad_keep_o), .ad_keep_val_o(ad_keep_val_o), .hi_out_o(hi_out_o),
        .hi_oe_n_o(hi_oe_n_o), .ctl_out_o(ctl_out_o), .ctl_oe_n_o(ctl_oe_n_o));

    xmc_ext_mem xmc_ext_mem_inst (.clock_i(clock_i), .ad_out_i(ad_out_o), .ad_oe_n_i(ad_oe_n_o),
        .ad_keep_i(ad_keep_o), .ad_keep_val_i(ad_keep_val_o), .hi_pin_i(hi_out_o),
        .ctl_out_i(ctl_out_o), .ad_pin_o(ad_pin_i));

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic sel, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= sel;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
        if (sel) begin
            ctrl_b = d & CTRL_B_WMASK;
        end else begin
            ctrl_a = d;
        end
    endtask

    task automatic reg_rd(input logic sel, input logic [7:0] exp);
        @(posedge clock_i);
        reg_addr_i <= sel;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(negedge clock_i);
        check(reg_rdata_o, exp, "register read");
    endtask

    // Sector choice: limit zero means everything is upper
    function automatic logic [1:0] sector_code(input logic [15:0] adr);
        if (ctrl_a[6:4] == 3'h0 || adr[15:13] >= ctrl_a[6:4]) begin
            return ctrl_a[3:2];
        end
        return ctrl_a[1:0];
    endfunction

    task automatic access(input logic [15:0] adr, input logic [7:0] d, input logic wr);
        int n;
        int nb;
        int lat;
        logic ext;
        logic [1:0] c;
        logic [15:0] ea;
        ext = ctrl_a[7] && adr > INT_SRAM_END_DEF;
        c = sector_code(adr);
        lat = 2 + int'(STROBE_BASE) + ((c == 2'h0) ? 0 : (c == 2'h1) ? 1 : 2) + ((c == 2'h3) ? 1 : 0);
        nb = (ctrl_b[2:0] == 3'h0) ? 8 : (ctrl_b[2:0] == 3'h7) ? 0 : 8 - int'(ctrl_b[2:0]);
        ea = adr;
        for (int i = 0; i < 8; i++) begin
            ea[8+i] = (i < nb) ? adr[8+i] : port_hi_i.out[i];
        end
        @(posedge clock_i);
        req_i <= '{addr: adr, wdata: d, write: wr};
        req_valid_i <= 1'b1;
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        n = 0;
        while (n < 50) begin
            @(negedge clock_i);
            n++;
            if (ctl_out_o[0] === 1'b1) begin
                check(ad_out_o, adr[7:0], "low address");
                check(ad_oe_n_o, 8'h00, "muxed drive");
                check(hi_out_o, ea[15:8], "high pins");
                check(hi_oe_n_o, 8'h00, "high enables");
                check(8'(ctl_oe_n_o), 8'h00, "control enables");
            end
            check(8'(req_ready_o), 8'h00, "busy while working");
            if (!ext) begin
                check(8'(ctl_out_o[2:1]), 8'h03, "strobes quiet");
            end
            if (done_o === 1'b1) begin
                break;
            end
        end
        if (n >= 50) begin
            error_cnt++;
            $display("FAIL at %0t: access never finished", $time);
            report_and_stop();
        end
        if (!ctrl_a[7]) begin
            check(8'(n), 8'h01, "off latency");
        end else if (ext) begin
            check(8'(n), 8'(lat), "wait states");
        end
        check(8'(ext_o), 8'(ext), "external flag");
        if (ext && wr) begin
            mem_model[int'(ea)] = d;
        end else if (!wr && (ext || !ctrl_a[7])) begin
            check(rdata_o, ext ? mem_model[int'(ea)] : UNMAPPED_DATA, "read data");
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(22278));
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        port_ad_i <= '{out: 8'($urandom), ddr: 8'h00};
        reg_rd(1'b0, CTRL_A_RESET);
        reg_rd(1'b1, CTRL_B_RESET);
        reg_wr(1'b1, 8'hFF);
        reg_rd(1'b1, CTRL_B_WMASK);
        @(negedge clock_i);
        check(ad_keep_o, 8'hFF, "keeper on, interface off");
        check(ad_out_o, port_ad_i.out, "port value");
        check(ad_oe_n_o, 8'hFF, "port direction");
        reg_wr(1'b1, 8'h00);
        @(negedge clock_i);
        check(ad_keep_o, 8'h00, "keeper off");
        access(16'h2000, 8'h00, 1'b0);
        for (int lim = 0; lim < 8; lim += 3) begin
            for (int cu = 0; cu < 4; cu++) begin
                reg_wr(1'b0, {1'b1, 3'(lim), 2'(cu), 2'(3 - cu)});
                reg_rd(1'b0, ctrl_a);
                repeat (2) begin
                    a = 16'($urandom_range(32'h1100, 32'hFFFF));
                    access(a, 8'($urandom), 1'b1);
                    access(a, 8'h00, 1'b0);
                end
            end
        end
        reg_wr(1'b0, 8'h80);
        for (int m = 0; m < 8; m++) begin
            reg_wr(1'b1, 8'(m));
            a = 16'($urandom_range(32'h1100, 32'hFFFF));
            access(a, 8'($urandom), 1'b1);
            access(a, 8'h00, 1'b0);
        end
        access(16'h0100, 8'h00, 1'b0);
        reg_wr(1'b0, 8'h00);
        @(negedge clock_i);
        check(ad_oe_n_o, 8'hFF, "pins returned");
        check(8'(ctl_out_o), 8'(port_ctl_i.out), "control pins returned");
        // Keeper with the interface off: drive the lines, release, level must stay
        reg_wr(1'b1, 8'h80);
        port_ad_i <= '{out: port_ad_i.out, ddr: 8'hFF};
        repeat (2) @(posedge clock_i);
        port_ad_i <= '{out: port_ad_i.out, ddr: 8'h00};
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        check(ad_keep_o, 8'hFF, "keeper on released lines");
        check(ad_keep_val_o, port_ad_i.out, "keeper holds level");
        report_and_stop();
    end
endmodule
